// ### include/acv_pkg.sv
package acv_pkg;
  // ==========================================================
  // widths and timing
  localparam int unsigned RES_BITS = 12;            // result width
  localparam int unsigned CODE_STEPS = 4096;        // full scale steps
  localparam int unsigned CLK_MHZ = 200;            // system clock rate
  localparam int unsigned CONV_MAX_NS = 750;        // longest conversion time
  // longest time rounds down, never below one cycle
  localparam int unsigned CONV_CYCLES_RAW = (CONV_MAX_NS * CLK_MHZ) / 1000;
  localparam int unsigned CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
  localparam int unsigned CNT_W = 8;                // conversion counter width
  localparam logic [RES_BITS-1:0] RES_RESET = 12'h000;  // result after reset
  localparam logic [RES_BITS-1:0] SAMPLE_STEP = 12'h001; // model sample increment

  // ==========================================================
  // host access modes
  typedef enum logic [3:0] {
    ACV_MODE_ALWAYS = 4'h1,   // cs and read tied low
    ACV_MODE_GATED = 4'h2,    // read strobe separate
    ACV_MODE_SLOWMEM = 4'h4,  // start and read joined, wait on busy
    ACV_MODE_ROM = 4'h8       // start and read joined, no wait
  } acv_mode_e;
endpackage

// ### include/acv_if.sv
`timescale 1ns/100ps
interface acv_if;
  import acv_pkg::*;
  logic chip_select_n;        // host drives
  logic conversion_start_n;   // host drives
  logic read_n;               // host drives
  logic power_down_n;         // host drives
  logic nap_sleep_select;     // host drives
  logic busy_n;               // device drives
  logic [RES_BITS-1:0] data_out;  // device drives
  logic data_oe;              // device drives, high while driving data
  modport device (input chip_select_n, input conversion_start_n, input read_n,
    input power_down_n, input nap_sleep_select, output busy_n, output data_out,
    output data_oe);
  modport host (output chip_select_n, output conversion_start_n, output read_n,
    output power_down_n, output nap_sleep_select, input busy_n, input data_out,
    input data_oe);
endinterface

// ### hw/acv_conv_timer.sv
`timescale 1ns/100ps
// ==========================================================
// conversion timer: counts a fixed number of cycles after a start
module acv_conv_timer #(
  parameter int unsigned CYCLES = acv_pkg::CONV_CYCLES,
  parameter int unsigned CW = acv_pkg::CNT_W
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,   // one-cycle start pulse
  output logic run_o,         // high while counting
  output logic done_o         // one-cycle pulse at end
);
  import acv_pkg::*;
  initial begin
    if (CYCLES < 1 || CYCLES >= (1 << CW)) begin
      $error("acv_conv_timer: CYCLES does not fit counter");
    end
  end
  logic [CW-1:0] count;  // cycles left
  // ==========================================================
  // countdown
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      count <= '0;
      run_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (run_o) begin
        if (count == CW'(1)) begin
          run_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count - CW'(1);
        end
      end else if (start_i) begin
        // a start while running is ignored by construction
        count <= CW'(CYCLES);
        run_o <= 1'b1;
      end
    end
  end
endmodule

// ### hw/acv_device.sv
`timescale 1ns/100ps
module acv_device #(
  parameter int unsigned CYCLES = acv_pkg::CONV_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  acv_if.device link,
  input wire logic [acv_pkg::RES_BITS-1:0] sample_i,  // held analog code
  output logic shutdown_o,      // high while shut down
  output logic sleep_o,         // high while in sleep flavour
  output logic conv_done_o      // one pulse per finished conversion
);
  import acv_pkg::*;
  initial begin
    if (CYCLES > CONV_CYCLES) begin
      $error("acv_device: conversion longer than the maximum");
    end
    if ((1 << RES_BITS) != CODE_STEPS) begin
      $error("acv_device: code width does not match step count");
    end
  end

  // ==========================================================
  // start edge detection
  logic start_q;      // previous start level
  logic start_fall;   // start went low this cycle
  logic take_start;   // accepted start
  logic run;          // timer running
  logic done;         // timer finished
  logic [RES_BITS-1:0] result;  // last completed result
  logic [RES_BITS-1:0] held;    // sample captured at start

  // falling edge: works for narrow low or narrow high pulses alike
  assign start_fall = start_q && !link.conversion_start_n;
  // chip select qualifies, shutdown blocks, running blocks
  assign take_start = start_fall && !link.chip_select_n && link.power_down_n
    && !run;

  // edge history; reset to high, so a start held low through reset fires once after reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      start_q <= 1'b1;
    end else begin
      start_q <= link.conversion_start_n;
    end
  end

  // ==========================================================
  // conversion timing
  acv_conv_timer #(.CYCLES(CYCLES), .CW(CNT_W)) u_timer (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .start_i(take_start),
    .run_o(run),
    .done_o(done)
  );

  // ==========================================================
  // sample and result
  // sample held at start; result replaced only at completion, so a read
  // during conversion still sees the previous word
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      held <= RES_RESET;
      result <= RES_RESET;
    end else begin
      if (take_start) begin
        held <= sample_i;
      end
      if (done) begin
        result <= held;
      end
    end
  end

  // ==========================================================
  // busy and data pins, all registered
  // busy rises one cycle after result updates, so the word is stable
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      link.busy_n <= 1'b1;
      link.data_out <= RES_RESET;
      link.data_oe <= 1'b0;
      conv_done_o <= 1'b0;
    end else begin
      if (take_start) begin
        link.busy_n <= 1'b0;
      end else if (!run && !done) begin
        link.busy_n <= 1'b1;
      end
      link.data_out <= done ? held : result;
      // drive only while selected and read low
      link.data_oe <= !link.chip_select_n && !link.read_n;
      conv_done_o <= done;
    end
  end

  // ==========================================================
  // shutdown flavour
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      shutdown_o <= 1'b0;
      sleep_o <= 1'b0;
    end else begin
      shutdown_o <= !link.power_down_n;
      sleep_o <= !link.power_down_n && !link.nap_sleep_select;
    end
  end
endmodule

// ### hw/acv_host.sv
`timescale 1ns/100ps
// ==========================================================
// host end: issues conversions in one of four modes and collects words
module acv_host #(
  parameter int unsigned PULSE_CYCLES = 2
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  acv_if.host link,
  input wire acv_pkg::acv_mode_e mode_i,   // access mode
  input wire logic req_i,                  // request one access
  input wire logic pulse_high_i,           // mode 1b high-going start pulse
  input wire logic power_down_n_i,         // shutdown request, low active
  input wire logic nap_sleep_select_i,     // shutdown flavour
  output logic ready_o,                    // idle, request accepted
  output logic valid_o,                    // one-cycle word strobe
  output logic [acv_pkg::RES_BITS-1:0] data_o
);
  import acv_pkg::*;
  initial begin
    if (PULSE_CYCLES < 1 || PULSE_CYCLES > 15) begin
      $error("acv_host: PULSE_CYCLES out of range");
    end
  end
  typedef enum logic [3:0] {
    ACV_H_IDLE = 4'h1,   // waiting for request
    ACV_H_PULSE = 4'h2,  // strobe asserted
    ACV_H_WAIT = 4'h4,   // waiting for busy to rise
    ACV_H_READ = 4'h8    // read strobe or capture
  } acv_hstate_e;
  acv_hstate_e state;
  logic [3:0] cnt;     // pulse width counter
  logic busy_q;        // previous busy level
  logic joined;        // start and read share one strobe
  assign joined = (mode_i == ACV_MODE_SLOWMEM) || (mode_i == ACV_MODE_ROM);

  // ==========================================================
  // sequencing
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state <= ACV_H_IDLE;
      cnt <= '0;
      busy_q <= 1'b1;
      ready_o <= 1'b0;
      valid_o <= 1'b0;
      data_o <= RES_RESET;
      link.chip_select_n <= 1'b1;
      link.conversion_start_n <= 1'b1;
      link.read_n <= 1'b1;
      link.power_down_n <= 1'b1;
      link.nap_sleep_select <= 1'b1;
    end else begin
      busy_q <= link.busy_n;
      valid_o <= 1'b0;
      link.power_down_n <= power_down_n_i;
      link.nap_sleep_select <= nap_sleep_select_i;
      link.chip_select_n <= 1'b0;
      // read tied low in always-enabled mode
      if (mode_i == ACV_MODE_ALWAYS && state == ACV_H_IDLE) begin
        link.read_n <= 1'b0;
      end
      case (state)
        ACV_H_IDLE: begin
          ready_o <= 1'b1;
          // mode 1b rests low; a high pulse then falls to start
          if (!joined) begin
            link.conversion_start_n <= !pulse_high_i;
          end
          if (req_i && ready_o) begin
            ready_o <= 1'b0;
            cnt <= 4'(PULSE_CYCLES);
            state <= ACV_H_PULSE;
            link.conversion_start_n <= pulse_high_i;
            if (joined) begin
              link.read_n <= 1'b0;
            end
          end
        end
        ACV_H_PULSE: begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) begin
            if (mode_i == ACV_MODE_ROM) begin
              // rom: capture the previous word, no wait
              data_o <= link.data_out;
              valid_o <= 1'b1;
              link.conversion_start_n <= 1'b1;
              link.read_n <= 1'b1;
              state <= ACV_H_WAIT;
            end else begin
              if (!joined) begin
                link.conversion_start_n <= !pulse_high_i;
              end
              state <= ACV_H_WAIT;
            end
          end
        end
        ACV_H_WAIT: begin
          // wait states while busy is low; act on its rising edge
          if (link.busy_n && !busy_q) begin
            if (mode_i == ACV_MODE_ROM) begin
              state <= ACV_H_IDLE;
            end else begin
              link.conversion_start_n <= joined ? 1'b1 : link.conversion_start_n;
              link.read_n <= (mode_i == ACV_MODE_ALWAYS) ? 1'b0 : 1'b0;
              state <= ACV_H_READ;
            end
          end
        end
        ACV_H_READ: begin
          // capture data_out and release read, which stays low in always-enabled mode
          data_o <= link.data_out;
          valid_o <= 1'b1;
          link.read_n <= (mode_i == ACV_MODE_ALWAYS) ? 1'b0 : 1'b1;
          state <= ACV_H_IDLE;
        end
        default: begin
          state <= ACV_H_IDLE;
        end
      endcase
    end
  end
endmodule

// ### tb/acv_sva.sv
`timescale 1ns/100ps
// ==========================================================
// link checker: host end and device end facing each other
module acv_sva #(
  parameter int unsigned CYCLES = 4
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic chip_select_n,
  input wire logic conversion_start_n,
  input wire logic read_n,
  input wire logic power_down_n,
  input wire logic busy_n,
  input wire logic [acv_pkg::RES_BITS-1:0] data_out,
  input wire logic data_oe
);
  import acv_pkg::*;
  logic [CNT_W-1:0] lo_cnt; // busy low time so far
  // ==========================================================
  // helper: cleared while busy is high, so each conversion counts alone
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || busy_n) begin
      lo_cnt <= '0;
    end else begin
      lo_cnt <= lo_cnt + 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // accepted start: selected, powered, idle, start falling
  sequence s_take;
    $fell(conversion_start_n) && !chip_select_n && power_down_n && busy_n;
  endsequence
  // ==========================================================
  // properties
  AST_TAKE: assert property (s_take |=> !busy_n)
    else $error("busy did not fall after start");
  AST_GATE: assert property ($fell(conversion_start_n) && (chip_select_n || !power_down_n)
    && busy_n |=> busy_n) else $error("start taken while deselected or down");
  AST_IDLE: assert property (busy_n && !$fell(conversion_start_n) |=> busy_n)
    else $error("busy fell without start");
  AST_LEN: assert property ($rose(busy_n) |-> lo_cnt == CNT_W'(CYCLES + 2))
    else $error("busy low time wrong");
  AST_MAX: assert property (!busy_n |-> lo_cnt <= CNT_W'(CYCLES + 1))
    else $error("conversion too long");
  AST_OLD: assert property (!busy_n && lo_cnt < CNT_W'(CYCLES + 1) |-> $stable(data_out))
    else $error("old result changed early");
  AST_NEW: assert property ($rose(busy_n) |-> $stable(data_out))
    else $error("result not ready before busy rise");
  AST_OE_ON: assert property (!chip_select_n && !read_n |=> data_oe)
    else $error("outputs not driven");
  AST_OE_OFF: assert property (read_n || chip_select_n |=> !data_oe)
    else $error("outputs driven without read");
endmodule

// ### tb/acv_bench.sv
`timescale 1ns/100ps
// ==========================================================
// bench: host and device joined, plus a bare device for misuse
module acv_bench;
  import acv_pkg::*;
  localparam int unsigned CYC = 4; // shortened conversion
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  acv_mode_e mode = ACV_MODE_ALWAYS;
  logic req = 1'b0, pol = 1'b0, pdn = 1'b1, nap = 1'b1;
  logic [RES_BITS-1:0] smp = 12'h000, at_rise = 12'h000, dat, w;
  logic rdy, vld, shd, slp, done, bprev;
  int n_errors = 0, n_compared = 0, ncyc = 0, ndone = 0, k;
  acv_if link ();
  acv_if lk2 (); // driven straight by the bench
  acv_device #(.CYCLES(CYC)) acv_device_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .link(link), .sample_i(smp), .shutdown_o(shd), .sleep_o(slp), .conv_done_o(done));
  acv_device #(.CYCLES(CYC)) acv_device_i2 (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .link(lk2), .sample_i(smp), .shutdown_o(), .sleep_o(), .conv_done_o());
  acv_host acv_host_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link),
    .mode_i(mode), .req_i(req), .pulse_high_i(pol), .power_down_n_i(pdn),
    .nap_sleep_select_i(nap), .ready_o(rdy), .valid_o(vld), .data_o(dat));
  acv_sva #(.CYCLES(CYC)) acv_sva_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .chip_select_n(link.chip_select_n), .conversion_start_n(link.conversion_start_n),
    .read_n(link.read_n), .power_down_n(link.power_down_n), .busy_n(link.busy_n),
    .data_out(link.data_out), .data_oe(link.data_oe));
  // ==========================================================
  // tasks
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one compare for every kind of result; flags are widened
  task automatic cmp(input string what, input logic [RES_BITS-1:0] e, g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  // one host access; request held until ready seen, then await word
  task automatic access(input acv_mode_e m, input logic p, input logic [RES_BITS-1:0] s);
    k = 0;
    mode <= m;
    pol <= p;
    smp <= s;
    req <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    req <= 1'b0;
    while (vld !== 1'b1 && k < 100) begin
      @(posedge clk_sys_i);
      k++;
    end
    w = dat;
    // a high-pulse access leaves start resting low; lift it before the next
    // access so a low-pulse start sees a real falling edge
    pol <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // bare device strobes, changed just after an edge
  task automatic drive(input logic cs, st, rd, pd);
    @(posedge clk_sys_i);
    lk2.chip_select_n <= cs;
    lk2.conversion_start_n <= st;
    lk2.read_n <= rd;
    lk2.power_down_n <= pd;
  endtask
  // ==========================================================
  // clock, timeout, word seen at busy rise, finished conversions
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    ncyc++;
    bprev <= link.busy_n;
    if (link.busy_n === 1'b1 && bprev === 1'b0) begin
      at_rise <= link.data_out;
    end
    if (done === 1'b1) begin
      ndone++;
    end
    if (ncyc > 3000) begin // far beyond the planned run
      n_errors++;
      complete_run();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    static logic [RES_BITS-1:0] tv [6] = '{12'h0a5, 12'h03c, 12'hfff, 12'h800, 12'h001,
      12'h5a3};
    static acv_mode_e tm [6] = '{ACV_MODE_ALWAYS, ACV_MODE_ALWAYS, ACV_MODE_GATED,
      ACV_MODE_SLOWMEM, ACV_MODE_ROM, ACV_MODE_ROM};
    lk2.chip_select_n = 1'b1;
    lk2.conversion_start_n = 1'b1;
    lk2.read_n = 1'b1;
    lk2.power_down_n = 1'b1;
    lk2.nap_sleep_select = 1'b1;
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    // every mode; rom hands back the word of the access before
    for (int i = 0; i < 6; i++) begin
      access(tm[i], i == 1, tv[i]);
      cmp("word", (tm[i] == ACV_MODE_ROM) ? tv[i-1] : tv[i], w);
      if (tm[i] != ACV_MODE_ROM) begin
        cmp("busy rise word", tv[i], at_rise);
      end
    end
    repeat (12) @(posedge clk_sys_i);
    cmp("conversions", 12'h006, RES_BITS'(ndone));
    // shutdown flavours
    pdn <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    cmp("shutdown", 12'h001, {11'h000, shd});
    cmp("nap", 12'h000, {11'h000, slp});
    nap <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    cmp("sleep", 12'h001, {11'h000, slp});
    pdn <= 1'b1;
    // bare device: deselected and powered-down starts are refused
    smp <= 12'h2c7;
    drive(1, 0, 1, 1);
    drive(1, 1, 1, 1);
    repeat (2) @(posedge clk_sys_i);
    cmp("busy deselected", 12'h001, {11'h000, lk2.busy_n});
    drive(0, 1, 1, 0);
    drive(0, 0, 1, 0);
    drive(0, 1, 1, 0);
    repeat (2) @(posedge clk_sys_i);
    cmp("busy shut down", 12'h001, {11'h000, lk2.busy_n});
    // start, then a second start mid-conversion that must be ignored
    drive(0, 1, 1, 1);
    drive(0, 0, 1, 1);
    drive(0, 1, 1, 1);
    drive(0, 0, 1, 1);
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (lk2.busy_n !== 1'b1 && k < 50);
    // counted from the edge after the accepted start: busy low for CYC + 2 edges
    cmp("busy time", RES_BITS'(CYC + 2), RES_BITS'(k));
    // outputs follow the read strobe while chip select is held low
    cmp("oe idle", 12'h000, {11'h000, lk2.data_oe});
    drive(0, 1, 0, 1);
    repeat (2) @(posedge clk_sys_i);
    cmp("oe read", 12'h001, {11'h000, lk2.data_oe});
    cmp("read word", 12'h2c7, lk2.data_out);
    drive(0, 1, 1, 1);
    repeat (2) @(posedge clk_sys_i);
    cmp("oe released", 12'h000, {11'h000, lk2.data_oe});
    complete_run();
  end
endmodule
